// ---- core/sqb_pkg.sv ----
package sqb_pkg;

  // ----------------------------------------------------------------
  // Array and pin geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int BANK_W = 2;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int LANES = 2;
  localparam int NUM_BANKS = 4;
  localparam int ROW_W = 12;
  localparam int COL_W = 8;
  localparam int PRECHARGE_SCOPE_BIT = 10;

  // ----------------------------------------------------------------
  // Mode word layout
  // ----------------------------------------------------------------
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_BL_W = 3;
  localparam int MODE_BT_BIT = 3;
  localparam int MODE_CL_LSB = 4;
  localparam int MODE_CL_W = 3;
  localparam int MODE_WB_BIT = 9;
  localparam logic [2:0] BL_FULL = 3'h7;
  localparam logic [2:0] CL_THREE = 3'h3;
  localparam logic [ADDR_W-1:0] MODE_RESET = 12'h020;

  // Commands as {row strobe, column strobe, write strobe}
  typedef enum logic [2:0] {
    CMD_LMR = 3'h0,
    CMD_REF = 3'h1,
    CMD_PRE = 3'h2,
    CMD_ACT = 3'h3,
    CMD_WR = 3'h4,
    CMD_RD = 3'h5,
    CMD_BST = 3'h6,
    CMD_NOP = 3'h7
  } sqb_cmd_t;

  // ----------------------------------------------------------------
  // Controller register map
  // ----------------------------------------------------------------
  localparam int WB_ADR_W = 8;
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_WDATA = 8'h04;
  localparam logic [7:0] REG_RDATA = 8'h08;
  localparam logic [7:0] REG_CTRL = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam int CMD_REG_W = 20;
  localparam int CMDF_CODE_LSB = 0;
  localparam int CMDF_CKE_OFF_BIT = 3;
  localparam int CMDF_BANK_LSB = 4;
  localparam int CMDF_LMASK_BIT = 6;
  localparam int CMDF_HMASK_BIT = 7;
  localparam int CMDF_ADDR_LSB = 8;
  localparam int CTRL_W = 2;
  localparam int CTRL_REF_EN_BIT = 0;
  localparam int CTRL_CKE_BIT = 1;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_REFDUE_BIT = 1;
  localparam int STAT_RCNT_LSB = 8;

  // ----------------------------------------------------------------
  // Refresh timing
  // ----------------------------------------------------------------
  localparam int REFRESH_WINDOW_MS = 64;
  localparam int REFRESH_OPS = 4096;
  localparam int CLK_KHZ = 200000;
  localparam int REFRESH_INTERVAL_CYC = REFRESH_WINDOW_MS * CLK_KHZ / REFRESH_OPS;

  // Burst length code to column wrap mask
  function automatic logic [COL_W-1:0] sqb_burst_mask(input logic [2:0] code);
    unique case (code)
      3'h0: return 8'h00;
      3'h1: return 8'h01;
      3'h2: return 8'h03;
      3'h3: return 8'h07;
      BL_FULL: return 8'hff;
      default: return 8'h00;
    endcase
  endfunction

endpackage

// ---- core/sqb_if.sv ----
`timescale 1ns/10ps
interface sqb_if;
  import sqb_pkg::*;

  // Command and address pins
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [BANK_W-1:0] bank_select_inputs;
  logic [ADDR_W-1:0] address_inputs;
  logic low_byte_mask;
  logic high_byte_mask;
  // Data pins, one drive per end
  logic [DATA_W-1:0] data_lines_ctl;
  logic data_lines_ctl_oe;
  logic [DATA_W-1:0] data_lines_mem;
  logic [LANES-1:0] data_lines_mem_oe;
  logic [DATA_W-1:0] data_lines;

  // Wire level per byte lane, undriven reads zero
  for (genvar l = 0; l < LANES; l++)
  begin : g_lane
    assign data_lines[l*BYTE_W +: BYTE_W] =
      data_lines_mem_oe[l] ? data_lines_mem[l*BYTE_W +: BYTE_W] :
      data_lines_ctl_oe ? data_lines_ctl[l*BYTE_W +: BYTE_W] : 8'h00;
  end

  modport ctl (
    output cke, cs_n, ras_n, cas_n, we_n, bank_select_inputs, address_inputs,
    output low_byte_mask, high_byte_mask, data_lines_ctl, data_lines_ctl_oe,
    input data_lines
  );

  modport mem (
    input cke, cs_n, ras_n, cas_n, we_n, bank_select_inputs, address_inputs,
    input low_byte_mask, high_byte_mask, data_lines,
    output data_lines_mem, data_lines_mem_oe
  );
endinterface

// ---- core/sqb_mem.sv ----
`timescale 1ns/10ps
// Summary of operation
// - All pins sampled on rising clock edge
// - Four banks, 4096 rows, 256 columns
// - Controller activates row before read or write
// - Activate takes bank and twelve-bit row
// - Read/write takes low eight bits as column
// - Bit 10 on access closes row after burst
// - Precharge bit 10 selects all or one bank
// - Bank inputs pick target bank
// - Mode load takes opcode from address pins
// - Burst 1,2,4,8 or page, with stop
// - Internal sequential or interleaved column order
// - Read latency two or three cycles
// - New column accepted every cycle
// - Burst writes or single writes by mode
// - Burst stop or precharge of its bank ends burst
// - Precharge one bank while another works
// - Controller refreshes 4096 times per 64 ms
// - Auto refresh, self refresh, power down
// - Command decoded from three strobes together
// - Clock gate low ignores the edge
// - Commands taken only with chip select low
// - Read byte mask floats that output lane
// - Write byte mask protects stored lane
module sqb_mem
  import sqb_pkg::*;
#(
  parameter int ROW_BITS = ROW_W,
  parameter int COL_BITS = COL_W
)
(
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Memory pins
  sqb_if.mem link
);

  localparam int IDX_W = BANK_W + ROW_BITS + COL_BITS;
  localparam int DEPTH = 1 << IDX_W;

  // Size check
  if (ROW_BITS < 1 || ROW_BITS > ADDR_W || COL_BITS < 1 || COL_BITS > COL_W)
  begin : g_bad_size
    $error("sqb_mem: unsupported array size");
  end

  typedef enum logic [1:0] {PWR_ACTIVE, PWR_DOWN, PWR_SELF} sqb_pwr_t;

  logic [ADDR_W-1:0] mode_r;
  sqb_pwr_t pwr_r;
  sqb_pwr_t pwr_nxt;
  logic bst_act_r;
  logic bst_rd_r;
  logic bst_ap_r;
  logic bst_full_r;
  logic [BANK_W-1:0] bst_bank_r;
  logic [COL_W-1:0] bst_start_r;
  logic [COL_W-1:0] bst_cnt_r;
  logic [COL_W-1:0] bst_mask_r;
  logic [DATA_W-1:0] rd_word;
  logic [DATA_W-1:0] rd2_r;
  logic [DATA_W-1:0] dq_r;
  logic v1_r;
  logic v2_r;
  logic [LANES-1:0] dqm_d_r;
  logic [LANES-1:0] oe_r;
  logic [NUM_BANKS-1:0] open_w;
  logic [ADDR_W-1:0] rows_w [NUM_BANKS];

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  wire live = link.cke;
  wire [2:0] code = {link.ras_n, link.cas_n, link.we_n};
  wire sel = live & ~link.cs_n;
  wire is_act = sel & (code == CMD_ACT);
  wire is_rd = sel & (code == CMD_RD);
  wire is_wr = sel & (code == CMD_WR);
  wire is_pre = sel & (code == CMD_PRE);
  wire is_bst = sel & (code == CMD_BST);
  wire is_lmr = sel & (code == CMD_LMR);
  wire [BANK_W-1:0] ba = link.bank_select_inputs;
  wire [ADDR_W-1:0] addr = link.address_inputs;
  wire ps_all = addr[PRECHARGE_SCOPE_BIT];
  wire [LANES-1:0] dqm = {link.high_byte_mask, link.low_byte_mask};

  // Mode fields
  wire [2:0] bl_code = mode_r[MODE_BL_LSB +: MODE_BL_W];
  wire interleave = mode_r[MODE_BT_BIT];
  wire cl3 = (mode_r[MODE_CL_LSB +: MODE_CL_W] == CL_THREE);
  wire single_wr = mode_r[MODE_WB_BIT];
  wire [COL_W-1:0] mode_mask = sqb_burst_mask(bl_code);

  // ----------------------------------------------------------------
  // Beat selection: a new access overrides a running burst
  // ----------------------------------------------------------------
  wire new_rw = is_rd | is_wr;
  wire wr_single = is_wr & single_wr;
  wire [COL_W-1:0] new_mask = wr_single ? 8'h00 : mode_mask;
  wire new_full = (bl_code == BL_FULL) & ~wr_single;
  wire bank_hit = (ba == bst_bank_r);
  wire stop_now = is_bst | (is_pre & (ps_all | bank_hit));
  wire beat_go = new_rw | (live & bst_act_r & ~stop_now);
  wire beat_rd = new_rw ? is_rd : bst_rd_r;
  wire [BANK_W-1:0] beat_bank = new_rw ? ba : bst_bank_r;
  wire [COL_W-1:0] beat_start = new_rw ? addr[COL_W-1:0] : bst_start_r;
  wire [COL_W-1:0] beat_mask = new_rw ? new_mask : bst_mask_r;
  wire [COL_W-1:0] beat_idx = new_rw ? 8'h00 : bst_cnt_r;
  wire beat_full = new_rw ? new_full : bst_full_r;
  wire beat_ap = new_rw ? addr[PRECHARGE_SCOPE_BIT] : bst_ap_r;
  wire beat_last = (beat_idx == beat_mask) & ~beat_full;

  // Column generation within the wrap window
  wire [COL_W-1:0] seq_sum = COL_W'(beat_start + beat_idx);
  wire [COL_W-1:0] seq_col = (beat_start & ~beat_mask) | (seq_sum & beat_mask);
  wire [COL_W-1:0] ilv_col = beat_start ^ beat_idx;
  wire [COL_W-1:0] beat_col = interleave ? ilv_col : seq_col;

  // Array index and access enables
  wire [ADDR_W-1:0] beat_row = rows_w[beat_bank];
  wire [IDX_W-1:0] beat_adr = {beat_bank, beat_row[ROW_BITS-1:0],
                               beat_col[COL_BITS-1:0]};
  wire row_ok = open_w[beat_bank];
  wire wr_go = beat_go & ~beat_rd & row_ok;
  wire rd_go = beat_go & beat_rd & row_ok;
  wire ap_close = beat_go & beat_last & beat_ap;

  // ----------------------------------------------------------------
  // Per bank row state
  // ----------------------------------------------------------------
  for (genvar b = 0; b < NUM_BANKS; b++)
  begin : g_bank
    logic open_r;
    logic [ADDR_W-1:0] row_r;
    wire hit = (ba == BANK_W'(b));
    wire own = (beat_bank == BANK_W'(b));
    wire close_b = (is_pre & (ps_all | hit)) | (ap_close & own);

    // Open on activate, close on precharge
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        open_r <= 1'b0;
        row_r <= 12'h000;
      end
      else if (is_act & hit)
      begin
        open_r <= 1'b1;
        row_r <= addr;
      end
      else if (close_b)
        open_r <= 1'b0;
    end

    assign open_w[b] = open_r;
    assign rows_w[b] = row_r;
  end

  // ----------------------------------------------------------------
  // Burst engine
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bst_act_r <= 1'b0;
      bst_rd_r <= 1'b0;
      bst_ap_r <= 1'b0;
      bst_full_r <= 1'b0;
      bst_bank_r <= 2'h0;
      bst_start_r <= 8'h00;
      bst_mask_r <= 8'h00;
      bst_cnt_r <= 8'h00;
    end
    else if (new_rw)
    begin
      bst_act_r <= ~beat_last;
      bst_rd_r <= is_rd;
      bst_ap_r <= addr[PRECHARGE_SCOPE_BIT];
      bst_full_r <= new_full;
      bst_bank_r <= ba;
      bst_start_r <= addr[COL_W-1:0];
      bst_mask_r <= new_mask;
      bst_cnt_r <= 8'h01;
    end
    else if (stop_now)
      bst_act_r <= 1'b0;
    else if (beat_go)
    begin
      bst_act_r <= ~beat_last;
      bst_cnt_r <= bst_cnt_r + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Mode word and power state
  // ----------------------------------------------------------------
  assign pwr_nxt = live ? PWR_ACTIVE :
                   (pwr_r != PWR_ACTIVE) ? pwr_r :
                   (~link.cs_n & (code == CMD_REF)) ? PWR_SELF : PWR_DOWN;

  // Mode load and power tracking; auto refresh needs no array action
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_r <= MODE_RESET;
      pwr_r <= PWR_ACTIVE;
    end
    else
    begin
      if (is_lmr)
        mode_r <= addr;
      pwr_r <= pwr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Storage, one array per byte lane
  // ----------------------------------------------------------------
  for (genvar l = 0; l < LANES; l++)
  begin : g_lane
    logic [BYTE_W-1:0] mem [DEPTH];
    logic [BYTE_W-1:0] q_r;
    wire we = wr_go & ~dqm[l];

    // Write unmasked lane only, read on read beats
    always_ff @(posedge clk_i)
    begin
      if (we)
        mem[beat_adr] <= link.data_lines[l*BYTE_W +: BYTE_W];
      if (rd_go)
        q_r <= mem[beat_adr];
    end

    assign rd_word[l*BYTE_W +: BYTE_W] = q_r;
  end

  // ----------------------------------------------------------------
  // Read latency pipeline and output drive
  // ----------------------------------------------------------------
  wire [DATA_W-1:0] out_word = cl3 ? rd2_r : rd_word;
  wire out_v = cl3 ? v2_r : v1_r;
  wire [LANES-1:0] out_oe = {LANES{out_v}} & ~dqm_d_r;

  // Pipeline frozen while the clock gate is low, output enables cleared in self refresh
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      v1_r <= 1'b0;
      v2_r <= 1'b0;
      rd2_r <= 16'h0000;
      dqm_d_r <= 2'h0;
      dq_r <= 16'h0000;
      oe_r <= 2'h0;
    end
    else if (live)
    begin
      v1_r <= rd_go;
      v2_r <= v1_r;
      rd2_r <= rd_word;
      dqm_d_r <= dqm;
      dq_r <= out_word;
      oe_r <= out_oe;
    end
    else if (pwr_nxt == PWR_SELF)
      oe_r <= 2'h0;
  end

  assign link.data_lines_mem = dq_r;
  assign link.data_lines_mem_oe = oe_r;

endmodule

// ---- core/sqb_ctl.sv ----
// The placing of the registers and the Wishbone slave port were decided locally.
`timescale 1ns/10ps
module sqb_ctl
  import sqb_pkg::*;
#(
  parameter int REFRESH_CYCLES = REFRESH_INTERVAL_CYC
)
(
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [WB_ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Memory link
  sqb_if.ctl link
);

  // Interval check
  if (REFRESH_CYCLES < 2 || REFRESH_CYCLES > 65535)
  begin : g_bad_ref
    $error("sqb_ctl: unsupported refresh interval");
  end

  logic ack_r;
  logic [31:0] dat_r;
  logic [CMD_REG_W-1:0] cmd_r;
  logic [DATA_W-1:0] wdata_r;
  logic [DATA_W-1:0] rdata_r;
  logic [CTRL_W-1:0] ctrl_r;
  logic [7:0] rcnt_r;
  logic pend_r;
  logic ref_due_r;
  logic [15:0] ref_cnt_r;
  logic cs_n_r;
  logic [2:0] code_r;
  logic [BANK_W-1:0] ba_r;
  logic [ADDR_W-1:0] addr_r;
  logic [LANES-1:0] dqm_r;
  logic [DATA_W-1:0] dq_r;
  logic dq_oe_r;
  logic [8:0] wr_left_r;
  logic [8:0] rd_left_r;
  logic [1:0] rd_dly_r;
  logic [2:0] sh_bl_r;
  logic [1:0] sh_cl_r;
  logic sh_single_r;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire req = wb_cyc_i & wb_stb_i & ~ack_r;
  wire wr = req & wb_we_i;
  wire [31:0] bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                       {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire hit_cmd = (wb_adr_i == REG_CMD);
  wire hit_wd = (wb_adr_i == REG_WDATA);
  wire hit_rd = (wb_adr_i == REG_RDATA);
  wire hit_ctrl = (wb_adr_i == REG_CTRL);
  wire hit_stat = (wb_adr_i == REG_STATUS);
  wire [31:0] cmd_m = (32'(cmd_r) & ~bmask) | (wb_dat_i & bmask);
  wire [31:0] wd_m = (32'(wdata_r) & ~bmask) | (wb_dat_i & bmask);
  wire [31:0] ctrl_m = (32'(ctrl_r) & ~bmask) | (wb_dat_i & bmask);
  wire [31:0] status = (32'(rcnt_r) << STAT_RCNT_LSB) |
                       (32'(ref_due_r) << STAT_REFDUE_BIT) |
                       (32'(pend_r) << STAT_BUSY_BIT);
  wire [31:0] rd_mux = hit_cmd ? 32'(cmd_r) :
                       hit_wd ? 32'(wdata_r) :
                       hit_rd ? 32'(rdata_r) :
                       hit_ctrl ? 32'(ctrl_r) :
                       hit_stat ? status : 32'h0;

  // ----------------------------------------------------------------
  // Issue decision
  // ----------------------------------------------------------------
  wire [2:0] cmd_code = cmd_r[CMDF_CODE_LSB +: 3];
  wire [ADDR_W-1:0] cmd_addr = cmd_r[CMDF_ADDR_LSB +: ADDR_W];
  wire cke_on = ctrl_r[CTRL_CKE_BIT];
  wire hold = (wr_left_r > 9'h001);
  wire do_ref = ref_due_r & ~hold & cke_on;
  wire do_cmd = pend_r & ~hold & ~ref_due_r;
  wire issue_wr = do_cmd & (cmd_code == CMD_WR);
  wire issue_rd = do_cmd & (cmd_code == CMD_RD);
  wire issue_lmr = do_cmd & (cmd_code == CMD_LMR);
  wire cke_drop = do_cmd & cmd_r[CMDF_CKE_OFF_BIT];
  wire [8:0] sh_len = 9'(sqb_burst_mask(sh_bl_r)) + 9'h001;
  wire [8:0] wr_len = sh_single_r ? 9'h001 : sh_len;
  wire ref_tick = ctrl_r[CTRL_REF_EN_BIT] & (ref_cnt_r == 16'(REFRESH_CYCLES - 1));

  // Wishbone answer one cycle after request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end
    else
    begin
      ack_r <= req;
      if (req)
        dat_r <= rd_mux;
    end
  end

  // Software registers; hardware clear loses to a write
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cmd_r <= 20'h00007;
      wdata_r <= 16'h0000;
      ctrl_r <= CTRL_RESET;
      pend_r <= 1'b0;
    end
    else
    begin
      if (wr & hit_cmd)
        cmd_r <= cmd_m[CMD_REG_W-1:0];
      if (wr & hit_wd)
        wdata_r <= wd_m[DATA_W-1:0];
      if (wr & hit_ctrl)
        ctrl_r <= ctrl_m[CTRL_W-1:0];
      else if (cke_drop)
        ctrl_r[CTRL_CKE_BIT] <= 1'b0;
      pend_r <= (wr & hit_cmd) | (pend_r & ~do_cmd);
    end
  end

  // Refresh interval timer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ref_cnt_r <= 16'h0000;
      ref_due_r <= 1'b0;
    end
    else
    begin
      ref_cnt_r <= (ref_tick | ~ctrl_r[CTRL_REF_EN_BIT]) ? 16'h0000 : ref_cnt_r + 16'h0001;
      ref_due_r <= ref_tick | (ref_due_r & ~do_ref & ctrl_r[CTRL_REF_EN_BIT]);
    end
  end

  // ----------------------------------------------------------------
  // Pin drive, one command per issue then deselect
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cs_n_r <= 1'b1;
      code_r <= CMD_NOP;
      ba_r <= 2'h0;
      addr_r <= 12'h000;
      dqm_r <= 2'h0;
    end
    else if (do_ref)
    begin
      cs_n_r <= 1'b0;
      code_r <= CMD_REF;
    end
    else if (do_cmd)
    begin
      cs_n_r <= 1'b0;
      code_r <= cmd_code;
      ba_r <= cmd_r[CMDF_BANK_LSB +: BANK_W];
      addr_r <= cmd_addr;
      dqm_r <= {cmd_r[CMDF_HMASK_BIT], cmd_r[CMDF_LMASK_BIT]};
    end
    else
    begin
      cs_n_r <= 1'b1;
      code_r <= CMD_NOP;
    end
  end

  // Mode copy for burst length and latency
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sh_bl_r <= MODE_RESET[MODE_BL_LSB +: MODE_BL_W];
      sh_cl_r <= 2'(MODE_RESET[MODE_CL_LSB +: MODE_CL_W]);
      sh_single_r <= MODE_RESET[MODE_WB_BIT];
    end
    else if (issue_lmr)
    begin
      sh_bl_r <= cmd_addr[MODE_BL_LSB +: MODE_BL_W];
      sh_cl_r <= 2'(cmd_addr[MODE_CL_LSB +: MODE_CL_W]);
      sh_single_r <= cmd_addr[MODE_WB_BIT];
    end
  end

  // Write data held for the whole burst
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_left_r <= 9'h000;
      dq_oe_r <= 1'b0;
      dq_r <= 16'h0000;
    end
    else if (issue_wr)
    begin
      wr_left_r <= wr_len;
      dq_oe_r <= 1'b1;
      dq_r <= wdata_r;
    end
    else if (wr_left_r != 9'h000)
    begin
      wr_left_r <= wr_left_r - 9'h001;
      if (wr_left_r == 9'h001)
        dq_oe_r <= 1'b0;
    end
  end

  // Read capture after the programmed latency
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rd_dly_r <= 2'h0;
      rd_left_r <= 9'h000;
      rdata_r <= 16'h0000;
      rcnt_r <= 8'h00;
    end
    else if (issue_rd)
    begin
      rd_dly_r <= sh_cl_r;
      rd_left_r <= 9'h000;
    end
    else if (rd_dly_r != 2'h0)
    begin
      rd_dly_r <= rd_dly_r - 2'h1;
      if (rd_dly_r == 2'h1)
        rd_left_r <= sh_len;
    end
    else if (rd_left_r != 9'h000)
    begin
      rd_left_r <= rd_left_r - 9'h001;
      rdata_r <= link.data_lines;
      rcnt_r <= rcnt_r + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign link.cke = ctrl_r[CTRL_CKE_BIT];
  assign link.cs_n = cs_n_r;
  assign link.ras_n = code_r[2];
  assign link.cas_n = code_r[1];
  assign link.we_n = code_r[0];
  assign link.bank_select_inputs = ba_r;
  assign link.address_inputs = addr_r;
  assign link.low_byte_mask = dqm_r[0];
  assign link.high_byte_mask = dqm_r[1];
  assign link.data_lines_ctl = dq_r;
  assign link.data_lines_ctl_oe = dq_oe_r;

endmodule

// ---- sim/sqb_asserts.sv ----
`timescale 1ns/10ps
module sqb_asserts
  import sqb_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link signals
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [BANK_W-1:0] bank_select_inputs,
  input wire logic [ADDR_W-1:0] address_inputs,
  input wire logic low_byte_mask,
  input wire logic high_byte_mask,
  input wire logic data_lines_ctl_oe,
  input wire logic [LANES-1:0] data_lines_mem_oe
);
  // ----------------------------------------------------------------
  // Link checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Decoded commands on the pins
  wire wr_cmd = !cs_n && {ras_n, cas_n, we_n} == CMD_WR;
  wire lmr_cmd = !cs_n && {ras_n, cas_n, we_n} == CMD_LMR;
  wire ref_cmd = !cs_n && {ras_n, cas_n, we_n} == CMD_REF;
  cmd_pulse_a:
    assert property (!cs_n |=> cs_n) else $error("command held over one cycle");
  post_reset_a:
    assert property ($fell(rst_i) |-> cs_n && cke && !data_lines_ctl_oe && !(|data_lines_mem_oe))
    else $error("link not idle after reset");
  strobe_idle_a:
    assert property (cs_n |-> {ras_n, cas_n, we_n} == CMD_NOP) else $error("strobes while idle");
  pin_hold_a:
    assert property (cs_n |-> $stable(address_inputs) && $stable(bank_select_inputs))
    else $error("address moved without command");
  write_drive_a:
    assert property (wr_cmd |-> data_lines_ctl_oe) else $error("write without data drive");
  drive_cause_a:
    assert property ($rose(data_lines_ctl_oe) |-> wr_cmd) else $error("data drive without write");
  low_float_a:
    assert property (data_lines_mem_oe[0] && $past(cke) && $past(cke, 2)
      |-> !$past(low_byte_mask, 2)) else $error("masked low lane driven");
  high_float_a:
    assert property (data_lines_mem_oe[1] && $past(cke) && $past(cke, 2)
      |-> !$past(high_byte_mask, 2)) else $error("masked high lane driven");
  // Main scenarios
  cover property (wr_cmd);
  cover property (lmr_cmd);
  cover property (data_lines_mem_oe == 2'h1);
  cover property (ref_cmd);
endmodule

// ---- sim/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  import sqb_pkg::*;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [WB_ADR_W-1:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [31:0] rd;
  logic [7:0] cnt = 8'h00;
  int fails = 0;
  int checks = 0;
  int seed = 46831;
  int ref_seen = 0;
  localparam int REF_INT = 20;
  sqb_if link();
  // Clock
  always #2.5 clk_i = ~clk_i;
  sqb_ctl #(.REFRESH_CYCLES(REF_INT)) sqb_ctl_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link(link));
  sqb_mem #(.ROW_BITS(4), .COL_BITS(8)) sqb_mem_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link));
  sqb_asserts sqb_asserts_inst (.clk_i(clk_i), .rst_i(rst_i), .cke(link.cke), .cs_n(link.cs_n),
    .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n),
    .bank_select_inputs(link.bank_select_inputs), .address_inputs(link.address_inputs),
    .low_byte_mask(link.low_byte_mask), .high_byte_mask(link.high_byte_mask),
    .data_lines_ctl_oe(link.data_lines_ctl_oe), .data_lines_mem_oe(link.data_lines_mem_oe));
  // Refresh commands seen on the pins
  always @(posedge clk_i)
    if (!link.cs_n && {link.ras_n, link.cas_n, link.we_n} == CMD_REF)
      ref_seen <= ref_seen + 1;
  // Words per burst for a length code from 0 to 3
  function automatic logic [7:0] beats(input logic [2:0] code);
    return 8'h01 << code;
  endfunction
  // Refreshes due within a span of cycles
  function automatic int ref_ops(input int span);
    return span / REF_INT;
  endfunction
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Verdict and end of run
  task automatic stop_test();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Compare one value
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      fails++;
    end
  endtask
  // Classic single Wishbone cycle
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hf;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1)
      @(posedge clk_i);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // Issue one link command and let it finish
  task automatic cmd(input logic [2:0] code, input logic [1:0] bk, input logic lm,
    input logic hm, input logic [11:0] adr);
    wb(1'b1, REG_CMD, {12'h0, adr, hm, lm, bk, 1'b0, code});
    rd = 32'h1;
    while (rd[0] === 1'b1)
      wb(1'b0, REG_STATUS, 32'h0);
    repeat (8) @(posedge clk_i);
  endtask
  // Captured word and beat count
  task automatic rdback(input logic [15:0] ex);
    wb(1'b0, REG_RDATA, 32'h0);
    chk("rdata", {16'h0, ex}, rd);
    wb(1'b0, REG_STATUS, 32'h0);
    chk("count", {24'h0, cnt}, {24'h0, rd[15:8]});
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [1:0] bk;
    logic [11:0] row;
    logic [7:0] col;
    logic [15:0] d1;
    logic [15:0] d2;
    logic [15:0] ex;
    logic [2:0] bl;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl", 32'h2, rd);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, rd);
    for (int i = 0; i < 6; i++)
    begin
      bk = 2'($random(seed));
      row = {8'h0, 4'($random(seed))};
      col = (i == 0) ? 8'hff : 8'($random(seed));
      d1 = 16'($random(seed));
      d2 = 16'($random(seed));
      bl = (i == 4) ? 3'h1 : 3'h0;
      cmd(CMD_LMR, 2'h0, 1'b0, 1'b0, {2'h0, i[0], 2'h0, i[1] ? 3'h3 : 3'h2, 1'b0, bl});
      cmd(CMD_ACT, bk, 1'b0, 1'b0, row);
      wb(1'b1, REG_WDATA, {16'h0, d1});
      cmd(CMD_WR, bk, 1'b0, 1'b0, {4'h0, col});
      wb(1'b1, REG_WDATA, {16'h0, d2});
      cmd(CMD_WR, bk, 1'b1, 1'b0, {4'h0, col});
      ex = {d2[15:8], d1[7:0]};
      cmd(CMD_RD, bk, 1'b0, 1'b1, {4'h0, col});
      cnt += beats(bl);
      rdback({8'h00, ex[7:0]});
      cmd(CMD_PRE, bk + 2'h1, 1'b0, 1'b0, 12'h000);
      cmd(CMD_RD, bk, 1'b0, 1'b0, {4'h4, col});
      cnt += beats(bl);
      rdback(ex);
      cmd(CMD_RD, bk, 1'b0, 1'b0, {4'h0, col});
      cnt += beats(bl);
      rdback(16'h0000);
      cmd(CMD_ACT, bk, 1'b0, 1'b0, row);
      cmd(CMD_PRE, bk + 2'h2, 1'b0, 1'b0, 12'h400);
      cmd(CMD_RD, bk, 1'b0, 1'b0, {4'h0, col});
      cnt += beats(bl);
      rdback(16'h0000);
    end
    wb(1'b1, REG_CTRL, 32'h3);
    repeat (100) @(posedge clk_i);
    wb(1'b1, REG_CTRL, 32'h2);
    chk("refresh", ref_ops(100), ref_seen);
    stop_test();
  end
  // Watchdog against a hang
  initial
  begin
    #200000;
    fails++;
    stop_test();
  end
endmodule
